// file: shared/ebp_pkg.sv
// Constants and state type of the enhanced bridge PWM unit
package ebp_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [3:0] ADDR_CONTROL   = 4'h0;
  localparam logic [3:0] ADDR_DUTY_HIGH = 4'h1;
  localparam logic [3:0] ADDR_DUTY_SHAD = 4'h2;
  localparam logic [3:0] ADDR_PERIOD    = 4'h3;
  localparam logic [3:0] ADDR_TIMER     = 4'h4;
  localparam logic [3:0] ADDR_TCTRL     = 4'h5;
  localparam logic [3:0] ADDR_DEADBAND  = 4'h6;
  localparam logic [3:0] ADDR_CAPT_LO   = 4'h7;
  localparam logic [3:0] ADDR_CAPT_HI   = 4'h8;
  localparam logic [3:0] ADDR_STATUS    = 4'h9;
  // ==========================================================
  // Field positions
  localparam int CTL_DIR      = 7;
  localparam int CTL_CFG_LSB  = 6;
  localparam int CTL_DLO_LSB  = 4;
  localparam int TC_CAPT_ON   = 7;
  localparam int TC_POST_LSB  = 3;
  localparam int TC_ON        = 2;
  localparam int TC_PRESC_LSB = 0;
  // ==========================================================
  // Encodings
  localparam logic [1:0] CFG_SINGLE   = 2'h0;
  localparam logic [1:0] CFG_FULL_FWD = 2'h1;
  localparam logic [1:0] CFG_HALF     = 2'h2;
  localparam logic [1:0] CFG_FULL_REV = 2'h3;
  localparam logic [3:0] MODE_OFF     = 4'h0;
  localparam logic [3:0] MODE_TOGGLE  = 4'h2;
  localparam logic [3:0] MODE_SET     = 4'h8;
  localparam logic [3:0] MODE_CLR     = 4'h9;
  localparam logic [3:0] MODE_SPECIAL = 4'hb;
  localparam logic [1:0] MODE_PWM     = 2'h3;
  localparam logic [1:0] MODE_CMP     = 2'h2;
  localparam logic [1:0] PRESC_1      = 2'h0;
  localparam logic [1:0] PRESC_4      = 2'h1;
  localparam logic [3:0] PLIM_1       = 4'h0;
  localparam logic [3:0] PLIM_4       = 4'h3;
  localparam logic [3:0] PLIM_16      = 4'hf;
  // ==========================================================
  // Timing: one core clock is one oscillator period
  localparam int CORE_CLK_NS    = 50;
  localparam int TOSC_NS        = 50;
  localparam int TOSC_PER_INSTR = 4;
  localparam int INSTR_CLKS     = TOSC_PER_INSTR * TOSC_NS / CORE_CLK_NS;
  localparam logic [1:0] Q_LAST = 2'(INSTR_CLKS - 1);
  // ==========================================================
  // Whole state of the unit
  typedef struct packed {
    logic [7:0]  pwm_control_reg;
    logic [7:0]  duty_high_bits_reg;
    logic [7:0]  duty_shadow_reg;
    logic [1:0]  duty_latch;
    logic [7:0]  period_limit_reg;
    logic [7:0]  period_timer;
    logic [7:0]  timer_ctrl;
    logic [6:0]  dead_band_reg;
    logic [6:0]  dead_work;
    logic [6:0]  db_cnt;
    logic [15:0] capture_timer;
    logic [1:0]  q;
    logic [3:0]  presc;
    logic [3:0]  post;
    logic [1:0]  sh_cfg;
    logic [1:0]  sh_pol;
    logic        running;
    logic        raw;
    logic        cmp_pin;
    logic [3:0]  pins;
    logic [3:0]  pin_en;
    logic [7:0]  rdata;
    logic        period_evt;
    logic        special_evt;
  } ebp_state_t;
  localparam ebp_state_t STATE_RST = '0;
endpackage : ebp_pkg

// file: verilog/ebp_top.sv
// Enhanced bridge PWM unit with compare timer and register port
//
// Overview of operation
// - Compare uses capture timer, PWM uses period timer
// - Special-event match clears whole capture timer
// - Config and mode pick which outputs are driven
// - PWM controls shadowed, loaded at period start
// - Dead-band loads at duty or period boundary
// - PWM starts only after period timer reset
// - Period end: clear timer, set output, copy duty
// - Period is four Tosc times limit+1 times prescale
// - Postscaler gives separate event, not PWM rate
// - Duty is ten bits, Tosc times prescale
// - Duty shadow loads on period match, read-only
// - Output clears when shadow equals fine timer
// - Duty beyond period never clears output
// - Half-bridge: A is PWM, B its complement
// - Half-bridge rising edges delayed by dead-band count
// - Dead-band over duty keeps output inactive
// - Full-bridge forward A on D modulated; reverse C,B
// - Direction change applies from next period
// - Last timer count before change: swap, modulated off
// - Full-bridge uses no dead-band delay
// - PWM modes set A/C and B/D polarity
// - Config codes single, forward, half, reverse
//
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module ebp_top (
  input  wire logic       I_CORE_CLK,
  input  wire logic       I_RESET,
  input  wire logic       I_CE,
  input  wire logic [3:0] I_ADDR,
  input  wire logic [7:0] I_WDATA,
  input  wire logic       I_WR,
  input  wire logic       I_RD,
  output logic      [7:0] O_RDATA,
  output logic            O_PWM_OUT_A,
  output logic            O_PWM_OUT_B,
  output logic            O_PWM_OUT_C,
  output logic            O_PWM_OUT_D,
  output logic            O_PWM_OUT_A_EN,
  output logic            O_PWM_OUT_B_EN,
  output logic            O_PWM_OUT_C_EN,
  output logic            O_PWM_OUT_D_EN,
  output logic            O_PERIOD_EVENT,
  output logic            O_SPECIAL_EVENT
);
  // ==========================================================
  // Declarations
  ebp_pkg::ebp_state_t st_reg;
  ebp_pkg::ebp_state_t st_next;
  logic [3:0] unit_mode_field;
  logic [1:0] output_config_field;
  logic       bridge_direction_bit;
  logic       pwm_req;
  logic       cmp_mode;
  logic       inst_tick;
  logic [3:0] presc_lim;
  logic [1:0] sub_bits;
  logic       tmr_tick;
  logic       at_limit;
  logic       period_end;
  logic [9:0] duty_pending;
  logic [9:0] duty_work;
  logic [9:0] fine_count;
  logic       duty_match;
  logic       raw_eff;
  logic       cmp_match;
  logic       full_mode;
  logic       dir_switch;
  logic [3:0] act;
  logic [3:0] pol;
  logic [3:0] pin_val;
  logic [3:0] en_val;
  logic [7:0] read_mux;

  // ==========================================================
  // Decode of pending control fields
  assign unit_mode_field      = st_reg.pwm_control_reg[3:0];
  assign output_config_field  = st_reg.pwm_control_reg[ebp_pkg::CTL_CFG_LSB +: 2];
  assign bridge_direction_bit = st_reg.pwm_control_reg[ebp_pkg::CTL_DIR];
  assign pwm_req  = unit_mode_field[3:2] == ebp_pkg::MODE_PWM;
  assign cmp_mode = (unit_mode_field == ebp_pkg::MODE_TOGGLE)
                  | (unit_mode_field[3:2] == ebp_pkg::MODE_CMP);

  // ==========================================================
  // Time base: sub-cycle, prescaler, period timer
  assign inst_tick = st_reg.q == ebp_pkg::Q_LAST;
  // Prescale limit and the two bits that extend the timer
  always_comb begin
    case (st_reg.timer_ctrl[ebp_pkg::TC_PRESC_LSB +: 2])
      ebp_pkg::PRESC_1: begin
        presc_lim = ebp_pkg::PLIM_1;
        sub_bits  = st_reg.q;
      end
      ebp_pkg::PRESC_4: begin
        presc_lim = ebp_pkg::PLIM_4;
        sub_bits  = st_reg.presc[1:0];
      end
      default: begin
        presc_lim = ebp_pkg::PLIM_16;
        sub_bits  = st_reg.presc[3:2];
      end
    endcase
  end
  // Timer steps once per instruction cycle times prescale
  assign tmr_tick = inst_tick & st_reg.timer_ctrl[ebp_pkg::TC_ON]
                  & (st_reg.presc == presc_lim);
  assign at_limit   = st_reg.period_timer == st_reg.period_limit_reg;
  assign period_end = tmr_tick & at_limit;

  // ==========================================================
  // Duty compare on the ten-bit fine count
  assign duty_pending = {st_reg.duty_high_bits_reg,
                         st_reg.pwm_control_reg[ebp_pkg::CTL_DLO_LSB +: 2]};
  assign duty_work  = {st_reg.duty_shadow_reg, st_reg.duty_latch};
  assign fine_count = {st_reg.period_timer, sub_bits};
  // No match is ever seen if the duty exceeds the fine range
  assign duty_match = st_reg.running & st_reg.raw & (fine_count == duty_work);
  // Output drops in the first cycle of the match, so the high time is
  // exactly duty counts; waiting for raw itself would add one Tosc
  assign raw_eff = st_reg.raw & ~duty_match;

  // Compare match against the capture timer
  assign cmp_match = cmp_mode & st_reg.timer_ctrl[ebp_pkg::TC_CAPT_ON] & inst_tick
                   & (st_reg.capture_timer == {st_reg.duty_shadow_reg,
                                               st_reg.duty_high_bits_reg});

  // ==========================================================
  // Output steering
  assign full_mode = st_reg.running & st_reg.sh_cfg[0];
  // Pending direction differs in the last timer count
  assign dir_switch = full_mode & pwm_req & output_config_field[0] & at_limit
                    & (bridge_direction_bit != st_reg.sh_cfg[1]);
  // Active levels before polarity
  always_comb begin
    act = 4'h0;
    if (st_reg.running) begin
      case (st_reg.sh_cfg)
        ebp_pkg::CFG_SINGLE: begin
          act[0] = raw_eff;
        end
        ebp_pkg::CFG_HALF: begin
          // Rising edges wait for the dead-band count
          act[0] = raw_eff & (st_reg.db_cnt == 7'h00);
          act[1] = ~raw_eff & (st_reg.db_cnt == 7'h00);
        end
        default: begin
          // No dead-band in full bridge, only two outputs on
          if (dir_switch) begin
            act[0] = ~bridge_direction_bit;
            act[2] = bridge_direction_bit;
          end else if (!st_reg.sh_cfg[1]) begin
            act[0] = 1'b1;
            act[3] = raw_eff;
          end else begin
            act[2] = 1'b1;
            act[1] = raw_eff;
          end
        end
      endcase
    end
  end
  // Polarity pairs A/C and B/D
  assign pol = {st_reg.sh_pol[0], st_reg.sh_pol[1], st_reg.sh_pol[0], st_reg.sh_pol[1]};
  // Pins not claimed stay ordinary port pins
  assign en_val = st_reg.running
                ? {{2{st_reg.sh_cfg[0]}}, st_reg.sh_cfg != ebp_pkg::CFG_SINGLE, 1'b1}
                : {3'h0, cmp_mode};
  assign pin_val = st_reg.running ? (act ^ pol) : {3'h0, st_reg.cmp_pin};

  // ==========================================================
  // Register read multiplexer, unmapped reads as zero
  always_comb begin
    case (I_ADDR)
      ebp_pkg::ADDR_CONTROL:   read_mux = st_reg.pwm_control_reg;
      ebp_pkg::ADDR_DUTY_HIGH: read_mux = st_reg.duty_high_bits_reg;
      ebp_pkg::ADDR_DUTY_SHAD: read_mux = st_reg.duty_shadow_reg;
      ebp_pkg::ADDR_PERIOD:    read_mux = st_reg.period_limit_reg;
      ebp_pkg::ADDR_TIMER:     read_mux = st_reg.period_timer;
      ebp_pkg::ADDR_TCTRL:     read_mux = st_reg.timer_ctrl;
      ebp_pkg::ADDR_DEADBAND:  read_mux = {1'b0, st_reg.dead_band_reg};
      ebp_pkg::ADDR_CAPT_LO:   read_mux = st_reg.capture_timer[7:0];
      ebp_pkg::ADDR_CAPT_HI:   read_mux = st_reg.capture_timer[15:8];
      ebp_pkg::ADDR_STATUS:    read_mux = {3'h0, st_reg.sh_cfg, st_reg.cmp_pin,
                                           st_reg.raw, st_reg.running};
      default:                 read_mux = 8'h00;
    endcase
  end

  // ==========================================================
  // Next state; the clock enable freezes everything
  always_comb begin
    st_next = st_reg;
    if (I_CE) begin
      st_next.period_evt  = 1'b0;
      st_next.special_evt = 1'b0;
      st_next.q = st_reg.q + 2'h1;
      // Prescaler and period timer
      // A smaller prescale takes over at once instead of wrapping the count
      if (inst_tick && st_reg.timer_ctrl[ebp_pkg::TC_ON]) begin
        st_next.presc = (st_reg.presc >= presc_lim) ? 4'h0 : st_reg.presc + 4'h1;
      end
      if (period_end) begin
        st_next.period_timer = 8'h00;
      end else if (tmr_tick) begin
        st_next.period_timer = st_reg.period_timer + 8'h01;
      end
      // Capture timer, cleared by the special event
      if (cmp_match && unit_mode_field == ebp_pkg::MODE_SPECIAL) begin
        st_next.capture_timer = 16'h0000;
        st_next.special_evt   = 1'b1;
      end else if (inst_tick && st_reg.timer_ctrl[ebp_pkg::TC_CAPT_ON]) begin
        st_next.capture_timer = st_reg.capture_timer + 16'h0001;
      end
      if (cmp_match) begin
        case (unit_mode_field)
          ebp_pkg::MODE_SET:    st_next.cmp_pin = 1'b1;
          ebp_pkg::MODE_CLR:    st_next.cmp_pin = 1'b0;
          ebp_pkg::MODE_TOGGLE: st_next.cmp_pin = ~st_reg.cmp_pin;
          default:              st_next.cmp_pin = st_reg.cmp_pin;
        endcase
      end
      // Period boundary: load the shadows (duty shadow only in PWM mode) and start
      if (period_end) begin
        st_next.running = pwm_req;
        st_next.sh_cfg  = output_config_field;
        st_next.sh_pol  = unit_mode_field[1:0];
        st_next.raw     = pwm_req & (duty_pending != 10'h000);
        if (pwm_req) begin
          st_next.duty_shadow_reg = st_reg.duty_high_bits_reg;
          st_next.duty_latch = st_reg.pwm_control_reg[ebp_pkg::CTL_DLO_LSB +: 2];
        end
        st_next.dead_work = st_reg.dead_band_reg;
        st_next.db_cnt    = st_reg.dead_band_reg;
        // Postscaler only paces an update event
        // A lowered postscale fires at the next period, not after a wrap
        if (st_reg.post >= st_reg.timer_ctrl[ebp_pkg::TC_POST_LSB +: 4]) begin
          st_next.post       = 4'h0;
          st_next.period_evt = 1'b1;
        end else begin
          st_next.post = st_reg.post + 4'h1;
        end
      end else if (duty_match) begin
        st_next.raw       = 1'b0;
        st_next.dead_work = st_reg.dead_band_reg;
        st_next.db_cnt    = st_reg.dead_band_reg;
      end else if (inst_tick && st_reg.db_cnt != 7'h00) begin
        st_next.db_cnt = st_reg.db_cnt - 7'h01;
      end
      // Mode off clears running, raw and the compare pin at once; timers keep counting
      if (unit_mode_field == ebp_pkg::MODE_OFF) begin
        st_next.running = 1'b0;
        st_next.raw     = 1'b0;
        st_next.cmp_pin = 1'b0;
      end
      // Registered pins
      st_next.pins   = pin_val;
      st_next.pin_en = en_val;
      // Software writes; a timer write overrides the count
      if (I_WR) begin
        case (I_ADDR)
          ebp_pkg::ADDR_CONTROL: begin
            st_next.pwm_control_reg = I_WDATA;
            if (I_WDATA[3:0] == ebp_pkg::MODE_SET) begin
              st_next.cmp_pin = 1'b0;
            end else if (I_WDATA[3:0] == ebp_pkg::MODE_CLR) begin
              st_next.cmp_pin = 1'b1;
            end
          end
          ebp_pkg::ADDR_DUTY_HIGH: st_next.duty_high_bits_reg = I_WDATA;
          ebp_pkg::ADDR_DUTY_SHAD: begin
            // Read-only while PWM owns the shadow
            if (!pwm_req && !st_reg.running) begin
              st_next.duty_shadow_reg = I_WDATA;
            end
          end
          ebp_pkg::ADDR_PERIOD:    st_next.period_limit_reg = I_WDATA;
          ebp_pkg::ADDR_TIMER:     st_next.period_timer = I_WDATA;
          ebp_pkg::ADDR_TCTRL:     st_next.timer_ctrl = I_WDATA;
          ebp_pkg::ADDR_DEADBAND:  st_next.dead_band_reg = I_WDATA[6:0];
          ebp_pkg::ADDR_CAPT_LO:   st_next.capture_timer[7:0] = I_WDATA;
          ebp_pkg::ADDR_CAPT_HI:   st_next.capture_timer[15:8] = I_WDATA;
          default:                 st_next.rdata = st_reg.rdata;
        endcase
      end
      // Read data stand only in the cycle after the strobe
      st_next.rdata = I_RD ? read_mux : 8'h00;
    end
  end

  // ==========================================================
  // State register, synchronous reset to all zero
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      st_reg <= ebp_pkg::STATE_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from flip-flops
  assign O_RDATA         = st_reg.rdata;
  assign O_PWM_OUT_A     = st_reg.pins[0];
  assign O_PWM_OUT_B     = st_reg.pins[1];
  assign O_PWM_OUT_C     = st_reg.pins[2];
  assign O_PWM_OUT_D     = st_reg.pins[3];
  assign O_PWM_OUT_A_EN  = st_reg.pin_en[0];
  assign O_PWM_OUT_B_EN  = st_reg.pin_en[1];
  assign O_PWM_OUT_C_EN  = st_reg.pin_en[2];
  assign O_PWM_OUT_D_EN  = st_reg.pin_en[3];
  assign O_PERIOD_EVENT  = st_reg.period_evt;
  assign O_SPECIAL_EVENT = st_reg.special_evt;

  // ==========================================================
  // Checks on the unit's own behaviour
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RESET);

  a_period_wrap: assert property (I_CE && period_end && !I_WR
    |=> st_reg.period_timer == 8'h00)
    else $error("period timer not cleared at period end");
  a_shadow_load: assert property (I_CE && period_end && pwm_req
    |=> st_reg.duty_shadow_reg == $past(st_reg.duty_high_bits_reg))
    else $error("duty shadow not loaded at period end");
  a_shadow_hold: assert property (I_CE && !period_end && st_reg.running
    |=> $stable(st_reg.duty_shadow_reg))
    else $error("duty shadow changed inside a period");
  a_zero_duty: assert property (I_CE && period_end && pwm_req
    && duty_pending == 10'h000 && unit_mode_field != ebp_pkg::MODE_OFF
    |=> !st_reg.raw)
    else $error("output set with zero duty");
  a_wait_start: assert property (I_CE && !st_reg.running && !period_end
    |=> !st_reg.running)
    else $error("PWM started away from period boundary");
  a_over_duty: assert property (I_CE && st_reg.raw && !period_end
    && duty_work > {st_reg.period_limit_reg, 2'h3}
    && unit_mode_field != ebp_pkg::MODE_OFF |=> st_reg.raw)
    else $error("output cleared although duty exceeds period");
  a_duty_clear: assert property (I_CE && duty_match && !period_end
    |=> !st_reg.raw)
    else $error("PWM output not cleared at duty match");
  a_dead_band: assert property (I_CE && st_reg.running
    && st_reg.sh_cfg == ebp_pkg::CFG_HALF && st_reg.db_cnt != 7'h00
    |=> st_reg.pins[1:0] == $past({st_reg.sh_pol[0], st_reg.sh_pol[1]}))
    else $error("half-bridge output active during dead band");
  a_full_fwd: assert property (I_CE && st_reg.running && !dir_switch
    && st_reg.sh_cfg == ebp_pkg::CFG_FULL_FWD
    |=> st_reg.pins[0] != $past(st_reg.sh_pol[1]) && st_reg.pins[2] == $past(st_reg.sh_pol[1]))
    else $error("forward bridge output A not held active");
  a_dir_switch: assert property (I_CE && dir_switch
    |=> st_reg.pins[3] == $past(st_reg.sh_pol[0]) && st_reg.pins[1] == $past(st_reg.sh_pol[0]))
    else $error("modulated outputs active during direction change");
  a_special_clr: assert property (I_CE && cmp_match
    && unit_mode_field == ebp_pkg::MODE_SPECIAL
    |=> st_reg.capture_timer == 16'h0000 && st_reg.special_evt)
    else $error("special event did not clear capture timer");
  a_single_pins: assert property (I_CE && st_reg.running
    && st_reg.sh_cfg == ebp_pkg::CFG_SINGLE |=> st_reg.pin_en == 4'h1)
    else $error("single mode claims extra pins");
  a_post_event: assert property (st_reg.period_evt
    |-> $past(I_CE) && $past(period_end))
    else $error("postscaler event away from period end");

  c_dir_change: cover property (I_CE && dir_switch ##1 I_CE && period_end);
  c_half_run:   cover property (st_reg.running && st_reg.sh_cfg == ebp_pkg::CFG_HALF
                                && st_reg.db_cnt != 7'h00);
  c_special:    cover property (st_reg.special_evt);
  c_duty_clear: cover property (I_CE && duty_match);
endmodule : ebp_top
`default_nettype wire

// file: sim/ebp_gate_model.sv
// Gate driver model of the power bridge fed by the PWM pins
`timescale 1ns/100ps
`default_nettype none
module ebp_gate_model (
  input  wire logic       i_clk,
  input  wire logic [3:0] i_pin,
  input  wire logic [3:0] i_en,
  input  wire logic [1:0] i_pol,
  output var  int         o_shoot
);
  logic [3:0] sw_on;
  // A switch conducts only when its pin is owned and at the active level
  assign sw_on = i_en & ~(i_pin ^ ~{i_pol[0], i_pol[1], i_pol[0], i_pol[1]});
  // Legs A/B and C/D shorting the supply would destroy real switches
  initial o_shoot = 0;
  always @(posedge i_clk) begin
    if ((sw_on[0] && sw_on[1]) || (sw_on[2] && sw_on[3])) o_shoot <= o_shoot + 1;
  end
endmodule : ebp_gate_model
`default_nettype wire

// file: sim/tb_top.sv
// Self-checking bench for the enhanced bridge PWM unit
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic       clk, rst, we, re, per_evt, spc_evt;
  logic [3:0] addr, pin, en;
  logic [7:0] wdata, rdata, rd_val;
  logic [1:0] pol;
  int         fails, cmp_count, seed, shoot, gate_cnt, n_evt, n_spc;
  int         hi [4];

  // ==========================================================
  // Clock, design and partner
  always #25 clk = ~clk;
  ebp_top u_ebp_top (
    .I_CORE_CLK(clk), .I_RESET(rst), .I_CE(1'b1), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WR(we), .I_RD(re), .O_RDATA(rdata), .O_PWM_OUT_A(pin[0]), .O_PWM_OUT_B(pin[1]),
    .O_PWM_OUT_C(pin[2]), .O_PWM_OUT_D(pin[3]), .O_PWM_OUT_A_EN(en[0]),
    .O_PWM_OUT_B_EN(en[1]), .O_PWM_OUT_C_EN(en[2]), .O_PWM_OUT_D_EN(en[3]),
    .O_PERIOD_EVENT(per_evt), .O_SPECIAL_EVENT(spc_evt));
  ebp_gate_model u_ebp_gate_model (.i_clk(clk), .i_pin(pin), .i_en(en), .i_pol(pol),
    .o_shoot(gate_cnt));

  // ==========================================================
  // Comparison, bus and sampling tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    we    <= 1'b1;
    @(posedge clk);
    we    <= 1'b0;
  endtask : wr
  // Read data stands only in the cycle after the strobe, so sample it there
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    re   <= 1'b1;
    @(posedge clk);
    re   <= 1'b0;
    #1 rd_val = rdata;
  endtask : rd
  task automatic measure(input int n);
    hi = '{0, 0, 0, 0};
    n_evt = 0;
    n_spc = 0;
    repeat (n) begin
      @(negedge clk);
      for (int k = 0; k < 4; k++) hi[k] += int'(pin[k]);
      n_evt += int'(per_evt);
      n_spc += int'(spc_evt);
    end
  endtask : measure
  task automatic finish_test;
    $display("comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : finish_test

  // ==========================================================
  // Expected high cycles of one pin over four periods, polarity applied
  function automatic int exp_hi(int p, int h, logic [1:0] cfg, logic [1:0] pm, int db, int k);
    int act [4];
    case (cfg)
      2'h0:    act = '{h, 0, 0, 0};
      2'h1:    act = '{p, 0, 0, h};
      2'h2:    act = '{h, p - h, 0, 0};
      default: act = '{0, h, p, 0};
    endcase
    if (cfg == 2'h2 && db * 4 > p) act = '{0, 0, 0, 0};
    return ((k % 2 == 0) ? pm[1] : pm[0]) ? 4 * (p - act[k]) : 4 * act[k];
  endfunction : exp_hi

  // One PWM run: program, let boundaries pass, then count four whole periods
  task automatic run(input int lim, input int duty, input int psel, input logic [1:0] cfg,
                     input logic [1:0] pm, input int db, input int r);
    int p;
    int h;
    p = 4 * (lim + 1) * ((psel == 0) ? 1 : (psel == 1) ? 4 : 16);
    h = duty * p / (4 * (lim + 1));
    h = (h > p) ? p : h;
    wr(4'h0, 8'h00);
    wr(4'h3, 8'(lim));
    wr(4'h1, 8'(duty >> 2));
    wr(4'h6, 8'(db));
    wr(4'h5, {1'b0, 4'((1 << r) - 1), 1'b1, 2'(psel)});
    wr(4'h4, 8'h00);
    wr(4'h0, {cfg, 2'(duty), 2'h3, pm});
    if (p >= 32) check(en, 4'h0);
    pol <= pm;
    repeat (3 * p) @(posedge clk);
    check(en, (cfg == 2'h0) ? 4'h1 : (cfg == 2'h2) ? 4'h3 : 4'hf);
    wr(4'h2, ~8'(duty >> 2));
    rd(4'h2);
    check(rd_val, 8'(duty >> 2));
    shoot = gate_cnt;
    measure(4 * p);
    for (int k = 0; k < 4; k++) begin
      if (en[k] === 1'b1) check(hi[k], exp_hi(p, h, cfg, pm, db, k));
    end
    check(n_evt, 4 >> r);
    check(gate_cnt - shoot, 0);
  endtask : run

  // ==========================================================
  // Main sequence and hang guard
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    {we, re, addr, wdata, pol} = '0;
    {fails, cmp_count} = '0;
    seed = 87161;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 16; a++) begin
      rd(4'(a));
      check(rd_val, 8'h00);
    end
    check(en, 4'h0);
    run(0, 2, 0, 2'h0, 2'h0, 0, 0);
    run(0, 0, 0, 2'h0, 2'h0, 0, 0);
    run(1, 63, 1, 2'h0, 2'h3, 0, 1);
    run(7, 10, 0, 2'h2, 2'h0, 127, 0);
    for (int i = 0; i < 8; i++) begin
      run($random(seed) & 7, $random(seed) & 63, i % 3, 2'(i), 2'($random(seed)),
          (i % 4 == 2) ? 0 : $random(seed) & 127, (i + 1) % 3);
    end
    // Direction change while running: forward, then reverse with no stop
    run(3, 8, 0, 2'h1, 2'h0, 0, 0);
    wr(4'h0, 8'hcc);
    shoot = gate_cnt;
    measure(64);
    check(gate_cnt - shoot, 0);
    measure(64);
    check(hi[2], 64);
    check(hi[1], 32);
    check(hi[0] + hi[3], 0);
    // Special event: compare value 5 must keep folding the capture timer back
    wr(4'h0, 8'h00);
    wr(4'h1, 8'h05);
    wr(4'h2, 8'h00);
    wr(4'h7, 8'h00);
    wr(4'h8, 8'h00);
    wr(4'h5, 8'h80);
    wr(4'h0, {4'h0, ebp_pkg::MODE_SPECIAL});
    measure(400);
    check(n_spc >= 13 && n_spc <= 20, 1'b1);
    repeat (6) begin
      rd(4'h8);
      check(rd_val, 8'h00);
      rd(4'h7);
      check(rd_val <= 8'h05, 1'b1);
    end
    finish_test();
  end
  initial begin
    repeat (100000) @(posedge clk);
    fails++;
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
